// File: verilog/reset_watchdog_pkg.sv
package reset_watchdog_pkg;

  // AHB-Lite register map (byte addresses)
  localparam logic [7:0] STATUS_OFFSET   = 8'h00;
  localparam logic [7:0] WDT_CTRL_OFFSET = 8'h04;
  localparam logic [7:0] ANALOG_OFFSET   = 8'h08;
  localparam logic [7:0] RESTART_OFFSET  = 8'h0c;

  // Cause flag positions in the status register
  localparam int POWER_UP_BIT = 0;
  localparam int PIN_BIT      = 1;
  localparam int DROOP_BIT    = 2;
  localparam int WATCHDOG_BIT = 3;

  // Watchdog control register field positions
  localparam int PERIOD_LO_MSB   = 2;
  localparam int ENABLE_BIT      = 3;
  localparam int UNLOCK_BIT      = 4;
  localparam int PERIOD_HI_BIT   = 5;
  localparam int IRQ_ENABLE_BIT  = 6;
  localparam int IRQ_FLAG_BIT    = 7;

  // Analog control register field positions
  localparam int BANDGAP_SEL_BIT = 0;
  localparam int CONV_ENABLE_BIT = 1;

  localparam logic [2:0] UNLOCK_WINDOW_CYCLES = 3'h4;
  localparam logic [3:0] PERIOD_CODE_MAX      = 4'h9;
  localparam logic [3:0] PERIOD_RESET         = 4'h0;
  localparam logic [3:0] FLAGS_RESET          = 4'h0;
  localparam int         BASE_PERIOD_LOG2     = 11;

  // Stretch lengths in system clock cycles for each start-up fuse code
  localparam logic [21:0] STRETCH_TABLE [4] = '{22'h000010, 22'h000400,
                                                22'h002000, 22'h010000};

  typedef struct packed {
    logic power_on;
    logic pin_low;
    logic droop;
  } reset_inputs_type;

  typedef struct packed {
    logic       irq_enable;
    logic       enable;
    logic [3:0] period;
  } wdt_config_type;

endpackage

// File: verilog/reset_and_watchdog_control.sv
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Any reset clears registers except the cause flags; core restarts at vector
// - Port reset asserts asynchronously with any source
// - Delay counter stretches reset by fuse-chosen time
// - Four causes: power-on, pin, watchdog, droop
// - Filtered pin low resets; the filter counts only on a running clk
// - Power-on detector reasserts reset instantly
// - Enabled droop resets at once, restarts after stretch
// - Droop recognised only after minimum duration
// - Watchdog reset pulse is one clock long
// - Watchdog counter runs on own 128 kHz oscillator
// - Counter cleared by restart, disable, chip reset
// - Ten selectable periods; expiry resets device
// - Expiry may raise interrupt instead, wakes sleep
// - Lock fuse picks safety level one or two
// - Level one: single write enables watchdog
// - Level one disable: unlock write, then within four
// - Level two: always running, enable reads one
// - Level two period change via unlock sequence
// - Bandgap on for droop fuse, comparator, converter
// - Codes 0..9 give 2048 to 1048576 cycles
// - Enable and irq-enable choose expiry action
// - Unlock bit self-clears after four cycles
// - Sticky cause flags; software writes zero to clear
module reset_and_watchdog_control
  import reset_watchdog_pkg::*;
#(
  parameter int PIN_FILTER_CYCLES   = 4,
  parameter int DROOP_FILTER_CYCLES = 4
)(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 wdt_osc_clk,
  input  wire logic                 power_on_low,
  input  wire logic                 reset_pin_n,
  input  wire logic                 supply_droop_detector,
  input  wire logic [2:0]           brownout_threshold_fuse,
  input  wire logic [1:0]           startup_time_fuse,
  input  wire logic [3:0]           clock_source_fuse,
  input  wire logic                 watchdog_lock_fuse_n,
  input  wire logic                 watchdog_restart_instruction,
  input  wire logic                 irq_ack,
  input  wire logic                 hsel,
  input  wire logic [7:0]           haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  output logic                      port_reset_n,
  output logic                      core_reset_n,
  output logic                      watchdog_irq,
  output logic                      bandgap_enable
);

  initial
  begin
    if (PIN_FILTER_CYCLES < 1 || PIN_FILTER_CYCLES > 255 ||
        DROOP_FILTER_CYCLES < 1 || DROOP_FILTER_CYCLES > 255)
      $error("filter lengths must be 1..255");
  end

  function automatic logic [20:0] period_limit(input logic [3:0] code);
    logic [3:0] safe;
    safe = (code > PERIOD_CODE_MAX) ? PERIOD_CODE_MAX : code;
    period_limit = 21'(21'h1 << (BASE_PERIOD_LOG2 + int'(safe))) - 21'h1;
  endfunction

  // ---------------- Reset sources ----------------
  reset_inputs_type src;
  logic [7:0]  pin_count;
  logic [7:0]  droop_count;
  logic        pin_reset;
  logic        droop_reset;
  logic        wdt_reset_pulse;
  logic        droop_enabled;
  logic        any_source;

  assign src.power_on = power_on_low;
  assign src.pin_low  = ~reset_pin_n;
  assign src.droop    = supply_droop_detector;
  assign droop_enabled = brownout_threshold_fuse != 3'h7;

  // Filters count on clk; with a stopped clock neither pin nor droop can assert reset
  always_ff @(posedge clk or posedge src.power_on)
  begin
    if (src.power_on)
      pin_count <= 8'h00;
    else if (!src.pin_low)
      pin_count <= 8'h00;
    else if (pin_count != 8'(PIN_FILTER_CYCLES))
      pin_count <= pin_count + 8'h01;
  end
  assign pin_reset = pin_count == 8'(PIN_FILTER_CYCLES);

  always_ff @(posedge clk or posedge src.power_on)
  begin
    if (src.power_on)
      droop_count <= 8'h00;
    else if (!(src.droop && droop_enabled))
      droop_count <= 8'h00;
    else if (droop_count != 8'(DROOP_FILTER_CYCLES))
      droop_count <= droop_count + 8'h01;
  end
  assign droop_reset = droop_count == 8'(DROOP_FILTER_CYCLES);

  // Any of the four causes or rst_n, power-on acting without a clock
  assign any_source = src.power_on | pin_reset | droop_reset | wdt_reset_pulse | ~rst_n;

  // ---------------- Stretch counter ----------------
  logic [21:0] stretch_count;
  logic [21:0] stretch_target;
  assign stretch_target = STRETCH_TABLE[startup_time_fuse] +
                          22'(clock_source_fuse);

  always_ff @(posedge clk or posedge any_source)
  begin
    if (any_source)
    begin
      stretch_count <= 22'h000000;
      port_reset_n  <= 1'b0;
      core_reset_n  <= 1'b0;
    end
    else
    begin
      port_reset_n <= 1'b1;
      if (stretch_count != stretch_target)
        stretch_count <= stretch_count + 22'h000001;
      core_reset_n <= stretch_count == stretch_target;
    end
  end

  // Chip reset for system-clock logic: async assert, released by stretch
  logic chip_rst_n;
  assign chip_rst_n = core_reset_n;

  // ---------------- Cause flags ----------------
  logic [3:0] cause_flags;
  logic [3:0] flag_clear;
  logic       status_write;

  always_ff @(posedge clk or posedge src.power_on)
  begin
    if (src.power_on)
      cause_flags <= 4'h1;
    else
    begin
      // Set wins over a simultaneous software clear
      cause_flags <= (cause_flags & ~flag_clear) |
                     {wdt_reset_pulse, droop_reset, pin_reset, 1'b0};
    end
  end

  // ---------------- Watchdog control (system clock) ----------------
  logic [3:0] period;
  logic       enable_bit;
  logic       irq_enable;
  logic       irq_flag;
  logic       unlock;
  logic [2:0] unlock_age;
  logic       level_two;
  logic [7:0] wdt_wdata;
  logic       wdt_write;
  logic       expiry_event;
  logic       wdt_running;
  logic       effective_enable;

  assign level_two        = ~watchdog_lock_fuse_n;
  assign effective_enable = level_two | enable_bit | cause_flags[WATCHDOG_BIT];
  assign wdt_running      = effective_enable | irq_enable;

  wdt_config_type next_cfg;
  always_comb
  begin
    next_cfg.irq_enable = irq_enable;
    next_cfg.enable     = enable_bit;
    next_cfg.period     = period;
    if (wdt_write)
    begin
      next_cfg.irq_enable = wdt_wdata[IRQ_ENABLE_BIT];
      if (wdt_wdata[ENABLE_BIT])
        next_cfg.enable = 1'b1;
      else if (unlock && !level_two)
        next_cfg.enable = 1'b0;
      if (!level_two || unlock)
        next_cfg.period = {wdt_wdata[PERIOD_HI_BIT], wdt_wdata[PERIOD_LO_MSB:0]};
    end
    if (expiry_event && irq_enable && effective_enable)
      next_cfg.irq_enable = 1'b0;
  end

  always_ff @(posedge clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
    begin
      period     <= PERIOD_RESET;
      enable_bit <= 1'b0;
      irq_enable <= 1'b0;
      irq_flag   <= 1'b0;
      unlock     <= 1'b0;
      unlock_age <= 3'h0;
    end
    else
    begin
      period     <= next_cfg.period;
      enable_bit <= next_cfg.enable;
      irq_enable <= next_cfg.irq_enable;
      irq_flag   <= (irq_flag & ~(irq_ack | (wdt_write & wdt_wdata[IRQ_FLAG_BIT]))) |
                    (expiry_event & irq_enable);
      if (wdt_write && wdt_wdata[UNLOCK_BIT] && wdt_wdata[ENABLE_BIT])
      begin
        unlock     <= 1'b1;
        unlock_age <= 3'h0;
      end
      else if (wdt_write || unlock_age == UNLOCK_WINDOW_CYCLES - 3'h1)
        unlock <= 1'b0;
      else if (unlock)
        unlock_age <= unlock_age + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
      watchdog_irq <= 1'b0;
    else
      watchdog_irq <= irq_flag & irq_enable;
  end

  // ---------------- Crossing to and from the watchdog oscillator ----------------
  logic restart_toggle;
  logic restart_req;
  always_ff @(posedge clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
      restart_toggle <= 1'b0;
    else if (restart_req)
      restart_toggle <= ~restart_toggle;
  end

  logic [2:0] restart_sync;
  logic [1:0] run_sync;
  logic       osc_rst_n_meta;
  logic       osc_rst_n;
  logic [20:0] wdt_count;
  logic        expiry_toggle;
  logic [3:0]  period_osc;

  // Oscillator-side reset: async assert, synchronised release
  always_ff @(posedge wdt_osc_clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
    begin
      osc_rst_n_meta <= 1'b0;
      osc_rst_n      <= 1'b0;
    end
    else
    begin
      osc_rst_n_meta <= 1'b1;
      osc_rst_n      <= osc_rst_n_meta;
    end
  end

  // Period is quasi-static; one flop samples it, a cycle ahead of the two-stage run level
  always_ff @(posedge wdt_osc_clk or negedge osc_rst_n)
  begin
    if (!osc_rst_n)
    begin
      restart_sync  <= 3'h0;
      run_sync      <= 2'h0;
      wdt_count     <= 21'h000000;
      expiry_toggle <= 1'b0;
      period_osc    <= PERIOD_RESET;
    end
    else
    begin
      restart_sync <= {restart_sync[1:0], restart_toggle};
      run_sync     <= {run_sync[0], wdt_running};
      period_osc   <= period;
      if (!run_sync[1] || (restart_sync[2] != restart_sync[1]))
        wdt_count <= 21'h000000;
      else if (wdt_count >= period_limit(period_osc))
      begin
        wdt_count     <= 21'h000000;
        expiry_toggle <= ~expiry_toggle;
      end
      else
        wdt_count <= wdt_count + 21'h000001;
    end
  end

  logic [2:0] expiry_sync;
  always_ff @(posedge clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
      expiry_sync <= 3'h0;
    else
      expiry_sync <= {expiry_sync[1:0], expiry_toggle};
  end
  assign expiry_event = expiry_sync[2] != expiry_sync[1];

  // Kept out of chip reset: the pulse feeds chip reset, so clearing it
  // there would shrink it to a glitch instead of one clk
  logic reset_pulse_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reset_pulse_q <= 1'b0;
    else
      reset_pulse_q <= expiry_event & effective_enable & ~irq_enable;
  end
  assign wdt_reset_pulse = reset_pulse_q;

  // ---------------- Analog control ----------------
  logic bandgap_sel;
  logic conv_enable;
  always_ff @(posedge clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
      bandgap_enable <= 1'b0;
    else
      bandgap_enable <= droop_enabled | bandgap_sel | conv_enable;
  end

  // ---------------- AHB-Lite slave ----------------
  logic       ph_write;
  logic       ph_valid;
  logic [7:0] ph_addr;
  logic       addr_take;

  assign addr_take = hsel & hready & htrans[1];

  always_ff @(posedge clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
    begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr  <= 8'h00;
    end
    else if (hready)
    begin
      ph_valid <= addr_take;
      ph_write <= hwrite;
      ph_addr  <= haddr;
    end
  end

  logic data_write;
  assign data_write   = ph_valid & ph_write;
  assign wdt_write    = data_write & (ph_addr == WDT_CTRL_OFFSET);
  assign status_write = data_write & (ph_addr == STATUS_OFFSET);
  assign restart_req  = watchdog_restart_instruction |
                        (data_write & (ph_addr == RESTART_OFFSET));
  assign wdt_wdata    = hwdata[7:0];
  assign flag_clear   = status_write ? ~hwdata[3:0] : 4'h0;

  always_ff @(posedge clk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
    begin
      bandgap_sel <= 1'b0;
      conv_enable <= 1'b0;
    end
    else if (data_write && ph_addr == ANALOG_OFFSET)
    begin
      bandgap_sel <= hwdata[BANDGAP_SEL_BIT];
      conv_enable <= hwdata[CONV_ENABLE_BIT];
    end
  end

  logic [31:0] read_mux;
  assign read_mux =
    (haddr == STATUS_OFFSET)   ? {28'h0, cause_flags} :
    (haddr == WDT_CTRL_OFFSET) ? {24'h0, irq_flag, irq_enable, period[3], unlock,
                                  effective_enable, period[2:0]} :
    (haddr == ANALOG_OFFSET)   ? {30'h0, conv_enable, bandgap_sel} : 32'h0;

  // Read data registered in the address phase: zero-wait answers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= (addr_take && !hwrite) ? read_mux : 32'h0;
    end
  end

endmodule

`default_nettype wire

// File: testbench/reset_watchdog_chk.sv
`timescale 1ns/1ps
`default_nettype none

module reset_watchdog_chk
  import reset_watchdog_pkg::*;
#(
  parameter int PIN_FILTER_CYCLES   = 4,
  parameter int DROOP_FILTER_CYCLES = 4
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        power_on_low,
  input  wire logic        reset_pin_n,
  input  wire logic        supply_droop_detector,
  input  wire logic [2:0]  brownout_threshold_fuse,
  input  wire logic [1:0]  startup_time_fuse,
  input  wire logic        hsel,
  input  wire logic        hready,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  input  wire logic [31:0] hrdata,
  input  wire logic        port_reset_n,
  input  wire logic        core_reset_n,
  input  wire logic        bandgap_enable
);
  logic [21:0] held;

  // Stretch cycles counted from the port side letting go
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      held <= 22'h0;
    else if (!port_reset_n)
      held <= 22'h0;
    else if (!core_reset_n)
      held <= held + 22'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence pin_held;
    !reset_pin_n [*6];
  endsequence

  // Filter is four cycles, so a one-cycle dip must pass unnoticed
  sequence short_dip;
    (core_reset_n && reset_pin_n && !power_on_low && !supply_droop_detector)
      ##1 supply_droop_detector ##1 (!supply_droop_detector && reset_pin_n) [*4];
  endsequence

  power_reset_a: assert property (power_on_low |-> !core_reset_n && !port_reset_n)
    else $error("power-on did not hold reset");
  port_before_core_a: assert property (!port_reset_n |-> !core_reset_n)
    else $error("core left reset before ports");
  stretch_len_a: assert property ($rose(core_reset_n) |-> held >= STRETCH_TABLE[startup_time_fuse])
    else $error("reset stretch too short");
  pin_reset_a: assert property (pin_held |-> !port_reset_n && !core_reset_n)
    else $error("long pin low gave no reset");
  droop_reset_a: assert property ((brownout_threshold_fuse != 3'h7) throughout supply_droop_detector [*6]
    |-> !core_reset_n)
    else $error("droop gave no reset");
  droop_glitch_a: assert property (short_dip |-> core_reset_n)
    else $error("short droop caused reset");
  bandgap_fuse_a: assert property ((brownout_threshold_fuse != 3'h7 && core_reset_n) ##1 core_reset_n
    |-> bandgap_enable)
    else $error("bandgap off with droop fuse set");
  bus_ready_a: assert property ($past(rst_n) |-> hreadyout && !hresp)
    else $error("bus not ready or not okay");
  read_idle_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
    else $error("read data outside data phase");
endmodule

`default_nettype wire

// File: testbench/core_model.sv
`timescale 1ns/1ps
`default_nettype none

module core_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [7:0]       haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  int timeouts = 0;

  initial
  begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
  end

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1 && n < 32)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 32)
      timeouts++;
  endtask

  // Unlock and follow-up writes are issued back to back to meet the window
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
endmodule

`default_nettype wire

// File: testbench/reset_and_watchdog_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("CHECK FAILED %s expected %h seen %h", n, e, g); \
    end \
  end

module reset_and_watchdog_control_tb;
  import reset_watchdog_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        wdt_osc_clk;
  logic        power_on_low;
  logic        reset_pin_n;
  logic        supply_droop_detector;
  logic [2:0]  brownout_threshold_fuse;
  logic [1:0]  startup_time_fuse;
  logic [3:0]  clock_source_fuse;
  logic        watchdog_lock_fuse_n;
  logic        watchdog_restart_instruction;
  logic        irq_ack;
  wire logic   hsel, hwrite, hreadyout, hresp, port_reset_n, core_reset_n;
  wire logic   watchdog_irq, bandgap_enable;
  wire logic [7:0]  haddr;
  wire logic [1:0]  htrans;
  wire logic [2:0]  hsize;
  wire logic [31:0] hwdata, hrdata;
  int          total_checks = 0;
  int          miscompares = 0;
  logic [31:0] seed = 32'h70c0;
  logic [31:0] q;
  logic [3:0]  per;

  reset_and_watchdog_control #(.PIN_FILTER_CYCLES(4), .DROOP_FILTER_CYCLES(4)) uut (
    .clk(clk), .rst_n(rst_n), .wdt_osc_clk(wdt_osc_clk), .power_on_low(power_on_low),
    .reset_pin_n(reset_pin_n), .supply_droop_detector(supply_droop_detector),
    .brownout_threshold_fuse(brownout_threshold_fuse), .startup_time_fuse(startup_time_fuse),
    .clock_source_fuse(clock_source_fuse), .watchdog_lock_fuse_n(watchdog_lock_fuse_n),
    .watchdog_restart_instruction(watchdog_restart_instruction), .irq_ack(irq_ack),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .port_reset_n(port_reset_n), .core_reset_n(core_reset_n),
    .watchdog_irq(watchdog_irq), .bandgap_enable(bandgap_enable));

  core_model core (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Phase offset keeps the watchdog oscillator unrelated to clk
  initial
  begin
    wdt_osc_clk = 1'b0;
    #1.3;
    forever #3906 wdt_osc_clk = ~wdt_osc_clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [31:0] cw(input logic ie, input logic en, input logic un,
                                     input logic [3:0] p);
    return {24'h0, 1'b0, ie, p[3], un, en, p[2:0]};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    core.xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string s, input logic [7:0] a, input logic [31:0] e);
    core.xfer(1'b0, a, 32'h0, q);
    `CHK(s, e, q)
  endtask

  task automatic give_verdict();
    miscompares += core.timeouts;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Bus logic sits in chip reset, so nothing is issued until the stretch ends
  task automatic wait_core();
    int n;
    n = 0;
    while (core_reset_n !== 1'b1 && n < 400)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 400)
    begin
      miscompares++;
      give_verdict();
    end
    cyc(2);
  endtask

  initial
  begin
    cyc(60000);
    miscompares++;
    give_verdict();
  end

  initial
  begin
    rst_n = 1'b0;
    power_on_low = 1'b1;
    reset_pin_n = 1'b1;
    supply_droop_detector = 1'b0;
    brownout_threshold_fuse = 3'h7;
    startup_time_fuse = 2'h0;
    clock_source_fuse = seed[3:0];
    watchdog_lock_fuse_n = 1'b1;
    watchdog_restart_instruction = 1'b0;
    irq_ack = 1'b0;
    cyc(2);
    power_on_low <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    wait_core();
    rd_chk("status", STATUS_OFFSET, 32'h1);
    rd_chk("wdt ctrl", WDT_CTRL_OFFSET, 32'h0);
    rd_chk("unmapped", 8'h10, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(ANALOG_OFFSET, 32'(i));
      cyc(2);
      `CHK("bandgap", (i != 0), bandgap_enable)
    end
    $display("test reset and bandgap done");
    wr(WDT_CTRL_OFFSET, cw(1'b0, 1'b1, 1'b0, 4'h0));
    rd_chk("enable", WDT_CTRL_OFFSET, cw(1'b0, 1'b1, 1'b0, 4'h0));
    wr(WDT_CTRL_OFFSET, 32'h0);
    rd_chk("locked", WDT_CTRL_OFFSET, cw(1'b0, 1'b1, 1'b0, 4'h0));
    wr(WDT_CTRL_OFFSET, cw(1'b0, 1'b1, 1'b1, 4'h0));
    wr(WDT_CTRL_OFFSET, 32'h0);
    rd_chk("disabled", WDT_CTRL_OFFSET, 32'h0);
    wr(WDT_CTRL_OFFSET, cw(1'b0, 1'b1, 1'b1, 4'h0));
    cyc(6);
    wr(WDT_CTRL_OFFSET, 32'h0);
    rd_chk("lapsed", WDT_CTRL_OFFSET, cw(1'b0, 1'b1, 1'b0, 4'h0));
    for (int i = 0; i < 6; i++)
    begin
      seed = xorshift(seed);
      per = (i == 0) ? 4'h9 : 4'(seed % 10);
      wr(WDT_CTRL_OFFSET, cw(1'b1, 1'b1, 1'b0, per));
      rd_chk("period", WDT_CTRL_OFFSET, cw(1'b1, 1'b1, 1'b0, per));
      wr(RESTART_OFFSET, seed);
    end
    watchdog_restart_instruction <= 1'b1;
    irq_ack <= 1'b1;
    cyc(1);
    watchdog_restart_instruction <= 1'b0;
    irq_ack <= 1'b0;
    cyc(2);
    `CHK("irq", 1'b0, watchdog_irq)
    $display("test level one done");
    wr(STATUS_OFFSET, 32'h0);
    rd_chk("cleared", STATUS_OFFSET, 32'h0);
    reset_pin_n <= 1'b0;
    cyc(1);
    reset_pin_n <= 1'b1;
    cyc(6);
    `CHK("short pin", 1'b1, core_reset_n)
    reset_pin_n <= 1'b0;
    cyc(8);
    reset_pin_n <= 1'b1;
    wait_core();
    rd_chk("pin flag", STATUS_OFFSET, 32'h2);
    rd_chk("chip reset", WDT_CTRL_OFFSET, 32'h0);
    brownout_threshold_fuse <= 3'h4;
    supply_droop_detector <= 1'b1;
    cyc(1);
    supply_droop_detector <= 1'b0;
    cyc(6);
    `CHK("short dip", 1'b1, core_reset_n)
    `CHK("bandgap fuse", 1'b1, bandgap_enable)
    supply_droop_detector <= 1'b1;
    cyc(8);
    supply_droop_detector <= 1'b0;
    wait_core();
    rd_chk("droop flag", STATUS_OFFSET, 32'h6);
    power_on_low <= 1'b1;
    cyc(3);
    power_on_low <= 1'b0;
    wait_core();
    rd_chk("power flag", STATUS_OFFSET, 32'h1);
    $display("test reset causes done");
    watchdog_lock_fuse_n <= 1'b0;
    rst_n <= 1'b0;
    cyc(4);
    rst_n <= 1'b1;
    wait_core();
    rd_chk("always on", WDT_CTRL_OFFSET, cw(1'b0, 1'b1, 1'b0, 4'h0));
    wr(WDT_CTRL_OFFSET, cw(1'b0, 1'b0, 1'b0, 4'h5));
    rd_chk("no change", WDT_CTRL_OFFSET, cw(1'b0, 1'b1, 1'b0, 4'h0));
    wr(WDT_CTRL_OFFSET, cw(1'b0, 1'b1, 1'b1, 4'h0));
    wr(WDT_CTRL_OFFSET, cw(1'b0, 1'b0, 1'b0, 4'h3));
    rd_chk("new period", WDT_CTRL_OFFSET, cw(1'b0, 1'b1, 1'b0, 4'h3));
    $display("test level two done");
    give_verdict();
  end
endmodule

bind reset_and_watchdog_control reset_watchdog_chk #(
  .PIN_FILTER_CYCLES(PIN_FILTER_CYCLES), .DROOP_FILTER_CYCLES(DROOP_FILTER_CYCLES)) chk (
  .clk(clk), .rst_n(rst_n), .power_on_low(power_on_low), .reset_pin_n(reset_pin_n),
  .supply_droop_detector(supply_droop_detector),
  .brownout_threshold_fuse(brownout_threshold_fuse), .startup_time_fuse(startup_time_fuse),
  .hsel(hsel), .hready(hready), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .port_reset_n(port_reset_n), .core_reset_n(core_reset_n),
  .bandgap_enable(bandgap_enable));

`default_nettype wire
